// [design/fss_pkg.sv]
package fss_pkg;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_PCT      = 8'h04;
  localparam logic [7:0] OFS_GAIN     = 8'h08;
  localparam logic [7:0] OFS_TI       = 8'h0C;
  localparam logic [7:0] OFS_DEMAG    = 8'h10;
  localparam logic [7:0] OFS_BRAKE    = 8'h14;
  localparam logic [7:0] OFS_RATED    = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1C;
  localparam logic [7:0] OFS_FREQ     = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  // search mode codes
  localparam logic [3:0] MODE_OFF    = 4'h0;
  localparam logic [3:0] MODE_REF    = 4'h1;
  localparam logic [3:0] MODE_CW_CCW = 4'h2;
  localparam logic [3:0] MODE_CCW_CW = 4'h3;
  localparam logic [3:0] MODE_CW     = 4'h4;
  localparam logic [3:0] MODE_CCW    = 4'h5;
  localparam logic [3:0] MODE_Q_BOTH = 4'hA;
  localparam logic [3:0] MODE_Q_REF  = 4'hB;
  localparam logic [3:0] MODE_Q_CW   = 4'hE;
  localparam logic [3:0] MODE_Q_CCW  = 4'hF;
  // settings: reset value and limits
  localparam logic [13:0] RST_PCT   = 14'h1B58;
  localparam logic [13:0] PCT_MIN   = 14'h0064;
  localparam logic [13:0] PCT_MAX   = 14'h2710;
  localparam logic [31:0] PCT_FULL  = 32'h0000_2710;
  localparam logic [9:0]  RST_GAIN  = 10'h064;
  localparam logic [9:0]  GAIN_MAX  = 10'h3E8;
  localparam logic signed [27:0] GAIN_UNIT = 28'sh0000064;
  localparam logic [9:0]  RST_TI    = 10'h014;
  localparam logic [9:0]  TI_MAX    = 10'h3E8;
  localparam logic [8:0]  RST_DEMAG = 9'h032;
  localparam logic [8:0]  DEMAG_MIN = 9'h001;
  localparam logic [8:0]  DEMAG_MAX = 9'h12C;
  localparam logic [10:0] RST_BRAKE = 11'h064;
  localparam logic [10:0] BRAKE_MAX = 11'h7D0;
  localparam logic [15:0] RST_RATED = 16'h1000;
  localparam logic [17:0] TENTH_MS  = 18'h00064;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  // interrupt and status bit positions
  localparam int IRQ_OK    = 0;
  localparam int IRQ_FAIL  = 1;
  localparam int IRQ_ABORT = 2;
  localparam int ST_BUSY   = 0;
  localparam int ST_DIR    = 1;
  localparam int ST_SEARCH = 2;
  localparam int ST_QUICK  = 3;
  localparam int ST_BRAKE  = 4;
endpackage : fss_pkg

// [design/fss_search_ctrl.sv]
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
// Contract
// - mode zero: no synchronization, start passes to the ordinary start path.
// - modes 1 and 11: search direction follows the reference sign.
// - mode 2: clockwise first, anticlockwise only after a failure.
// - mode 3: anticlockwise first, clockwise only after a failure.
// - modes 4/14 clockwise only, 5/15 anticlockwise only.
// - mode 10: quick test pulses in both directions, no search run.
// - quick modes accelerate from the detected value unless overcurrent.
// - with synchronization on, start first triggers the search.
// - modes 1-5: setpoint is 1-100 % of rated current, default 70 %.
// - PI loop on search current; gain to 10, Ti to 1 s; zero disables.
// - modes 1-5: search waits until the demagnetizing time elapsed.
// - failed search in modes 1-5: brake current for 0-200 s, default 10 s.
// - success: accelerate from detected speed at the configured rate.
// - quick modes have no failure detection and no fallback.
// - demagnetizing time 0.1 s to 30 s, default 5 s.
module fss_search_ctrl #(
  parameter int MS_CYCLES = fss_pkg::MS_CYCLES
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  input  wire logic [fss_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [31:0]               regWdata,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic      [31:0]               regRdata,
  input  wire logic                      startCmd,
  input  wire logic                      refNegative,
  input  wire logic [15:0]               curMeas,
  input  wire logic                      searchLock,
  input  wire logic                      searchFail,
  input  wire logic                      quickDone,
  input  wire logic [15:0]               detectedFreq,
  input  wire logic                      detDirCcw,
  input  wire logic                      overCurrent,
  output logic                           normalStart,
  output logic                           searchActive,
  output logic                           searchDirCcw,
  output logic                           testPulse,
  output logic      [15:0]               currentSetpoint,
  output logic      [15:0]               piOut,
  output logic                           dcInjectionBrake,
  output logic                           accelStart,
  output logic      [15:0]               startFreq,
  output logic                           startDirCcw,
  output logic                           resultOk,
  output logic                           resultFail,
  output logic                           irq
);
  import fss_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_DEMAG, S_SEARCH, S_QUICK, S_BRAKE} fss_state_type;

  typedef struct packed {
    fss_state_type      st;
    logic [3:0]         mode;
    logic [13:0]        pct;
    logic [9:0]         gain;
    logic [9:0]         ti;
    logic [8:0]         demag;
    logic [10:0]        brake;
    logic [15:0]        rated;
    logic [2:0]         irqStat;
    logic [2:0]         irqMask;
    logic [31:0]        rdata;
    logic [16:0]        pre;
    logic [17:0]        timer;
    logic [9:0]         tiCnt;
    logic signed [23:0] integ;
    logic               second;
    logic               dir;
    logic [15:0]        sp;
    logic [15:0]        pi;
    logic [15:0]        freq;
    logic               fdir;
    logic               accel;
    logic               normal;
    logic               okP;
    logic               failP;
  } fss_regs_type;

  fss_regs_type r;
  fss_regs_type next_r;

  logic               msTick;
  logic [17:0]        demagMs;
  logic [17:0]        brakeMs;
  logic [31:0]        spProd;
  logic [15:0]        spCalc;
  logic signed [16:0] err;
  logic signed [27:0] pProd;
  logic signed [27:0] pSum;
  logic               twoStep;

  assign msTick  = r.pre == 17'(MS_CYCLES - 1);
  assign demagMs = 18'(r.demag) * TENTH_MS;
  assign brakeMs = 18'(r.brake) * TENTH_MS;
  assign spProd  = 32'(r.rated) * 32'(r.pct);
  assign spCalc  = 16'(spProd / PCT_FULL);
  assign err     = $signed({1'b0, r.sp}) - $signed({1'b0, curMeas});
  assign pProd   = 28'(err * $signed({1'b0, r.gain}));
  assign pSum    = pProd / GAIN_UNIT + 28'(r.integ);
  assign twoStep = r.mode == MODE_CW_CCW || r.mode == MODE_CCW_CW;

  always_comb begin
    logic [2:0] ev;
    ev = '0;
    next_r = r;
    next_r.rdata  = '0;
    next_r.accel  = 1'b0;
    next_r.normal = 1'b0;
    next_r.okP    = 1'b0;
    next_r.failP  = 1'b0;
    next_r.pre    = msTick ? '0 : r.pre + 17'h00001;
    if (msTick && r.timer != '1) begin
      next_r.timer = r.timer + 18'h00001;
    end
    if (regWr) begin
      case (regAddr)
        OFS_MODE: next_r.mode = regWdata[3:0];
        OFS_PCT: begin
          if (regWdata < 32'(PCT_MIN)) next_r.pct = PCT_MIN;
          else if (regWdata > 32'(PCT_MAX)) next_r.pct = PCT_MAX;
          else next_r.pct = regWdata[13:0];
        end
        OFS_GAIN: next_r.gain = regWdata > 32'(GAIN_MAX) ? GAIN_MAX : regWdata[9:0];
        OFS_TI: next_r.ti = regWdata > 32'(TI_MAX) ? TI_MAX : regWdata[9:0];
        OFS_DEMAG: begin
          if (regWdata < 32'(DEMAG_MIN)) next_r.demag = DEMAG_MIN;
          else if (regWdata > 32'(DEMAG_MAX)) next_r.demag = DEMAG_MAX;
          else next_r.demag = regWdata[8:0];
        end
        OFS_BRAKE: next_r.brake = regWdata > 32'(BRAKE_MAX) ? BRAKE_MAX : regWdata[10:0];
        OFS_RATED: next_r.rated = regWdata[15:0];
        OFS_IRQ_STAT: next_r.irqStat = r.irqStat & ~regWdata[2:0];
        OFS_IRQ_MASK: next_r.irqMask = regWdata[2:0];
        default: ;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        OFS_MODE: next_r.rdata = 32'(r.mode);
        OFS_PCT: next_r.rdata = 32'(r.pct);
        OFS_GAIN: next_r.rdata = 32'(r.gain);
        OFS_TI: next_r.rdata = 32'(r.ti);
        OFS_DEMAG: next_r.rdata = 32'(r.demag);
        OFS_BRAKE: next_r.rdata = 32'(r.brake);
        OFS_RATED: next_r.rdata = 32'(r.rated);
        OFS_STATUS: begin
          next_r.rdata[ST_BUSY]   = r.st != S_IDLE;
          next_r.rdata[ST_DIR]    = r.dir;
          next_r.rdata[ST_SEARCH] = r.st == S_SEARCH;
          next_r.rdata[ST_QUICK]  = r.st == S_QUICK;
          next_r.rdata[ST_BRAKE]  = r.st == S_BRAKE;
        end
        OFS_FREQ: next_r.rdata = {15'h0000, r.fdir, r.freq};
        OFS_IRQ_STAT: next_r.rdata = 32'(r.irqStat);
        OFS_IRQ_MASK: next_r.rdata = 32'(r.irqMask);
        default: ;
      endcase
    end
    // setpoint only while the search run regulates current
    next_r.sp = r.st == S_SEARCH ? spCalc : '0;
    next_r.pi = '0;
    unique case (r.st)
      S_IDLE: begin
        next_r.timer  = '0;
        next_r.tiCnt  = '0;
        next_r.integ  = '0;
        next_r.second = 1'b0;
        if (startCmd) begin
          unique case (r.mode)
            MODE_REF: begin
              next_r.dir = refNegative;
              next_r.st  = S_DEMAG;
            end
            MODE_CW_CCW, MODE_CW: begin
              next_r.dir = 1'b0;
              next_r.st  = S_DEMAG;
            end
            MODE_CCW_CW, MODE_CCW: begin
              next_r.dir = 1'b1;
              next_r.st  = S_DEMAG;
            end
            MODE_Q_BOTH, MODE_Q_CW: begin
              next_r.dir = 1'b0;
              next_r.st  = S_QUICK;
            end
            MODE_Q_REF: begin
              next_r.dir = refNegative;
              next_r.st  = S_QUICK;
            end
            MODE_Q_CCW: begin
              next_r.dir = 1'b1;
              next_r.st  = S_QUICK;
            end
            // off and unused codes fall back to the plain start
            default: next_r.normal = 1'b1;
          endcase
        end
      end
      S_DEMAG: begin
        if (r.timer >= demagMs) begin
          next_r.st    = S_SEARCH;
          next_r.timer = '0;
        end
      end
      S_SEARCH: begin
        // output clamped to a non-negative voltage demand
        if (pSum < 0) next_r.pi = '0;
        else if (pSum > 28'sh000FFFF) next_r.pi = 16'hFFFF;
        else next_r.pi = pSum[15:0];
        if (r.ti == '0) begin
          next_r.integ = '0;
          next_r.tiCnt = '0;
        end else if (msTick) begin
          if (r.tiCnt + 10'h001 >= r.ti) begin
            next_r.tiCnt = '0;
            next_r.integ = r.integ + 24'(err);
          end else begin
            next_r.tiCnt = r.tiCnt + 10'h001;
          end
        end
        if (searchLock) begin
          next_r.accel = 1'b1;
          next_r.freq  = detectedFreq;
          next_r.fdir  = r.dir;
          next_r.okP   = 1'b1;
          ev[IRQ_OK]   = 1'b1;
          next_r.st    = S_IDLE;
        end else if (searchFail) begin
          if (twoStep && !r.second) begin
            next_r.second = 1'b1;
            next_r.dir    = ~r.dir;
          end else begin
            next_r.st    = S_BRAKE;
            next_r.timer = '0;
          end
        end
      end
      S_BRAKE: begin
        if (r.timer >= brakeMs) begin
          next_r.st     = S_IDLE;
          next_r.failP  = 1'b1;
          ev[IRQ_FAIL]  = 1'b1;
        end
      end
      S_QUICK: begin
        // search failure is meaningless here; only overcurrent aborts it
        if (overCurrent) begin
          next_r.st     = S_IDLE;
          next_r.failP  = 1'b1;
          ev[IRQ_ABORT] = 1'b1;
        end else if (quickDone) begin
          if (r.mode == MODE_Q_BOTH && !r.second) begin
            next_r.second = 1'b1;
            next_r.dir    = 1'b1;
          end else begin
            next_r.accel = 1'b1;
            next_r.freq  = detectedFreq;
            next_r.fdir  = r.mode == MODE_Q_BOTH ? detDirCcw : r.dir;
            next_r.okP   = 1'b1;
            ev[IRQ_OK]   = 1'b1;
            next_r.st    = S_IDLE;
          end
        end
      end
    endcase
    // an event in the clearing cycle survives
    next_r.irqStat = next_r.irqStat | ev;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      r         <= '0;
      r.st      <= S_IDLE;
      r.pct     <= RST_PCT;
      r.gain    <= RST_GAIN;
      r.ti      <= RST_TI;
      r.demag   <= RST_DEMAG;
      r.brake   <= RST_BRAKE;
      r.rated   <= RST_RATED;
    end else begin
      r <= next_r;
    end
  end

  assign regRdata         = r.rdata;
  assign normalStart      = r.normal;
  assign searchActive     = r.st != S_IDLE;
  assign searchDirCcw     = r.dir;
  assign testPulse        = r.st == S_QUICK;
  assign currentSetpoint  = r.sp;
  assign piOut            = r.pi;
  assign dcInjectionBrake = r.st == S_BRAKE;
  assign accelStart       = r.accel;
  assign startFreq        = r.freq;
  assign startDirCcw      = r.fdir;
  assign resultOk         = r.okP;
  assign resultFail       = r.failP;
  assign irq              = |(r.irqStat & r.irqMask);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_off;
    r.st == S_IDLE && startCmd && r.mode == MODE_OFF |=> normalStart && !searchActive;
  endproperty
  a_off: assert property (p_off) else $error("mode off started a search");

  property p_refdir;
    r.st == S_IDLE && startCmd && r.mode == MODE_REF |=> searchDirCcw == $past(refNegative)
      && r.st == S_DEMAG;
  endproperty
  a_refdir: assert property (p_refdir) else $error("reference sign not followed");

  property p_fallback;
    r.st == S_SEARCH && r.mode == MODE_CW_CCW && !r.second && !searchLock && searchFail
      |=> r.st == S_SEARCH && searchDirCcw;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no anticlockwise retry");
  property p_fallback_ccw;
    r.st == S_SEARCH && r.mode == MODE_CCW_CW && !r.second && !searchLock && searchFail
      |=> r.st == S_SEARCH && !searchDirCcw;
  endproperty
  a_fallback_ccw: assert property (p_fallback_ccw) else $error("no clockwise retry");

  property p_only;
    searchActive && (r.mode == MODE_CW || r.mode == MODE_Q_CW) |-> !searchDirCcw;
  endproperty
  a_only: assert property (p_only) else $error("wrong direction in clockwise-only");

  property p_quick_both;
    r.st == S_QUICK && r.mode == MODE_Q_BOTH && !r.second && quickDone && !overCurrent
      |=> testPulse && searchDirCcw && !accelStart;
  endproperty
  a_quick_both: assert property (p_quick_both) else $error("second quick test missing");
  property p_quick_go;
    r.st == S_QUICK && r.second && quickDone && !overCurrent
      |=> accelStart && startFreq == $past(detectedFreq) ##1 !accelStart;
  endproperty
  a_quick_go: assert property (p_quick_go) else $error("quick result not used");

  property p_demag;
    r.st == S_DEMAG && r.timer < demagMs |=> r.st == S_DEMAG && currentSetpoint == '0;
  endproperty
  a_demag: assert property (p_demag) else $error("search started before demagnetizing");
  property p_brake;
    r.st == S_SEARCH && !searchLock && searchFail && (r.second || !twoStep)
      |=> dcInjectionBrake && !resultFail;
  endproperty
  a_brake: assert property (p_brake) else $error("no brake after failed search");

  property p_pi_off;
    (r.st == S_SEARCH && r.gain == '0 && r.ti == '0)[*2] |-> piOut == '0;
  endproperty
  a_pi_off: assert property (p_pi_off) else $error("disabled PI still drives");
  property p_quick_nofail;
    r.st == S_QUICK && searchFail && !quickDone && !overCurrent |=> testPulse && !resultFail;
  endproperty
  a_quick_nofail: assert property (p_quick_nofail) else $error("quick mode fell back");
  property p_lock;
    r.st == S_SEARCH && searchLock |=> accelStart && resultOk && !searchActive
      && startFreq == $past(detectedFreq);
  endproperty
  a_lock: assert property (p_lock) else $error("lock did not start acceleration");
endmodule : fss_search_ctrl

// [bench/fss_motor_model.sv]
`timescale 1ns/10ps
module fss_motor_model #(
  parameter int DLY = 600
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] currentSetpoint,
  input  wire logic        searchDirCcw,
  input  wire logic        testPulse,
  input  wire logic        motorCcw,
  input  wire logic [15:0] motorFreq,
  input  wire logic        ocReq,
  output logic      [15:0] curMeas,
  output logic             searchLock,
  output logic             searchFail,
  output logic             quickDone,
  output logic      [15:0] detectedFreq,
  output logic             detDirCcw,
  output logic             overCurrent
);
  int   cnt;
  logic lastDir;
  logic hit;
  // loaded rotor draws half the setpoint, keeps the loop error predictable
  assign curMeas      = currentSetpoint >> 1;
  assign overCurrent  = ocReq;
  assign hit          = (cnt == DLY);
  // estimate lines only mean something beside a result pulse
  assign detectedFreq = (searchLock || quickDone) ? motorFreq : ~motorFreq;
  assign detDirCcw    = quickDone ? motorCcw : ~motorCcw;
  assign searchLock   = hit && !testPulse && (searchDirCcw == motorCcw);
  // stray failure report midway through a quick test; the design must ignore it
  assign searchFail   = testPulse ? (cnt == DLY / 2) : hit && (searchDirCcw != motorCcw);
  assign quickDone    = hit && testPulse;
  always_ff @(posedge ref_clk) begin
    lastDir <= searchDirCcw;
    if (!rstn || hit || lastDir != searchDirCcw
        || !(testPulse || currentSetpoint != 16'h0000)) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : fss_motor_model

// [bench/test_flying_start_search_control.sv]
`timescale 1ns/10ps
module test_flying_start_search_control;
  import fss_pkg::*;
  logic        ref_clk, rstn, regWr, regRd, startCmd, refNegative, motorCcw, ocReq;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata;
  logic [15:0] curMeas, detectedFreq, currentSetpoint, piOut, startFreq, motorFreq;
  logic        searchLock, searchFail, quickDone, detDirCcw, overCurrent, normalStart;
  logic        searchActive, searchDirCcw, testPulse, dcInjectionBrake, accelStart;
  logic        startDirCcw, resultOk, resultFail, irq;
  logic        d1, flip;
  logic [15:0] sp, pi1, pi2;
  int          dem, brk, error_cnt, cmp_count;

  fss_search_ctrl #(.MS_CYCLES(10)) DUT (.ref_clk, .rstn, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .startCmd, .refNegative, .curMeas, .searchLock, .searchFail,
    .quickDone, .detectedFreq, .detDirCcw, .overCurrent, .normalStart, .searchActive,
    .searchDirCcw, .testPulse, .currentSetpoint, .piOut, .dcInjectionBrake, .accelStart,
    .startFreq, .startDirCcw, .resultOk, .resultFail, .irq);
  fss_motor_model #(.DLY(600)) u_motor (.ref_clk, .rstn, .currentSetpoint, .searchDirCcw,
    .testPulse, .motorCcw, .motorFreq, .ocReq, .curMeas, .searchLock, .searchFail,
    .quickDone, .detectedFreq, .detDirCcw, .overCurrent);

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk(nm, exp, regRdata);
  endtask : rc

  // one start attempt; results left in d1, flip, dem, brk, sp, pi1, pi2
  task automatic run(input logic [3:0] m, input logic rn, input logic mc);
    int i;
    wr(OFS_MODE, {28'h0000000, m});
    refNegative <= rn;
    motorCcw    <= mc;
    startCmd    <= 1'b1;
    @(posedge ref_clk);
    startCmd <= 1'b0;
    #1;
    dem = 0;
    brk = 0;
    flip = 0;
    while (currentSetpoint === 16'h0000 && testPulse !== 1'b1 && dem < 1500) begin
      @(posedge ref_clk);
      #1 dem++;
    end
    sp = currentSetpoint;
    d1 = searchDirCcw;
    for (i = 0; i < 4000 && accelStart !== 1'b1 && resultFail !== 1'b1; i++) begin
      if (searchDirCcw !== d1) flip = 1;
      if (dcInjectionBrake === 1'b1) brk++;
      if (i == 100) pi1 = piOut;
      if (i == 500) pi2 = piOut;
      if (i == 300) rc(OFS_STATUS, {28'h0000000, m[3], ~m[3], d1, 1'b1}, "status");
      @(posedge ref_clk);
      #1;
    end
  endtask : run

  task automatic t_regs;
    rc(OFS_PCT, 32'h00001B58, "pct");
    rc(OFS_GAIN, 32'h00000064, "gain");
    rc(OFS_TI, 32'h00000014, "ti");
    rc(OFS_DEMAG, 32'h00000032, "demag");
    rc(OFS_BRAKE, 32'h00000064, "brake");
    rc(8'h3C, 32'h00000000, "unmapped");
    wr(OFS_PCT, 32'h00000000);
    rc(OFS_PCT, 32'h00000064, "pct low");
    wr(OFS_PCT, 32'h00004E20);
    rc(OFS_PCT, 32'h00002710, "pct high");
    wr(OFS_DEMAG, 32'h00000000);
    rc(OFS_DEMAG, 32'h00000001, "demag low");
    wr(OFS_DEMAG, 32'h00000190);
    rc(OFS_DEMAG, 32'h0000012C, "demag high");
    wr(OFS_BRAKE, 32'h00000FFF);
    rc(OFS_BRAKE, 32'h000007D0, "brake high");
    wr(OFS_GAIN, 32'h000007FF);
    rc(OFS_GAIN, 32'h000003E8, "gain high");
    // short times keep the run brief; rated 10000 makes setpoint equal pct
    wr(OFS_DEMAG, 32'h00000001);
    wr(OFS_BRAKE, 32'h00000001);
    wr(OFS_RATED, 32'h00002710);
    wr(OFS_PCT, 32'h00001B58);
    wr(OFS_GAIN, 32'h00000064);
    wr(OFS_TI, 32'h00000000);
    wr(OFS_IRQ_MASK, 32'h00000001);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_off;
    logic seen;
    for (int k = 0; k < 2; k++) begin
      seen = 0;
      wr(OFS_MODE, k == 0 ? 32'h00000000 : 32'h00000007);
      startCmd <= 1'b1;
      @(posedge ref_clk);
      startCmd <= 1'b0;
      #1;
      repeat (3) begin
        seen |= normalStart;
        @(posedge ref_clk);
        #1;
      end
      chk("normal start", 32'h1, {31'h0, seen});
      chk("idle", 32'h0, {31'h0, searchActive});
    end
    $display("t_off done");
  endtask : t_off

  task automatic t_ref;
    motorFreq <= 16'h0123;
    run(MODE_REF, 1'b1, 1'b1);
    chk("dir", 32'h1, {31'h0, d1});
    chk("demag wait", 32'h1, {31'h0, dem >= 990 && dem <= 1015});
    chk("setpoint", 32'h00001B58, {16'h0, sp});
    chk("pi p", 32'h00000DAC, {16'h0, pi1});
    chk("ok", 32'h1, {31'h0, resultOk});
    chk("freq", 32'h00000123, {16'h0, startFreq});
    chk("sdir", 32'h1, {31'h0, startDirCcw});
    repeat (2) @(posedge ref_clk);
    #1 chk("irq set", 32'h1, {31'h0, irq});
    rc(OFS_FREQ, 32'h00010123, "freq reg");
    wr(OFS_IRQ_STAT, 32'h00000001);
    @(posedge ref_clk);
    #1 chk("irq clr", 32'h0, {31'h0, irq});
    wr(OFS_GAIN, 32'h00000000);
    run(MODE_REF, 1'b0, 1'b0);
    chk("dir pos", 32'h0, {31'h0, d1});
    chk("pi off", 32'h0, {16'h0, pi1});
    $display("t_ref done");
  endtask : t_ref

  task automatic t_pair;
    run(MODE_CW_CCW, 1'b0, 1'b1);
    chk("m2 first", 32'h0, {31'h0, d1});
    chk("m2 flip", 32'h1, {31'h0, flip});
    chk("m2 end", 32'h1, {31'h0, startDirCcw});
    run(MODE_CCW_CW, 1'b0, 1'b0);
    chk("m3 first", 32'h1, {31'h0, d1});
    chk("m3 flip", 32'h1, {31'h0, flip});
    chk("m3 end", 32'h0, {31'h0, startDirCcw});
    $display("t_pair done");
  endtask : t_pair

  task automatic t_single;
    wr(OFS_IRQ_STAT, 32'h00000007);
    run(MODE_CW, 1'b1, 1'b1);
    chk("m4 dir", 32'h0, {31'h0, d1 | flip});
    chk("m4 fail", 32'h1, {31'h0, resultFail});
    chk("brake time", 32'h1, {31'h0, brk >= 985 && brk <= 1015});
    rc(OFS_IRQ_STAT, 32'h00000002, "fail flag");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFS_TI, 32'h00000014);
    run(MODE_CCW, 1'b0, 1'b1);
    chk("m5 dir", 32'h1, {31'h0, d1 & ~flip});
    chk("integ", 32'h1, {31'h0, pi2 >= 16'h1B58});
    $display("t_single done");
  endtask : t_single

  task automatic t_quick;
    logic [3:0] qm [3] = '{MODE_Q_REF, MODE_Q_CW, MODE_Q_CCW};
    logic       qr [3] = '{1'b1, 1'b0, 1'b0};
    logic       qc [3] = '{1'b0, 1'b1, 1'b0};
    logic       qd [3] = '{1'b1, 1'b0, 1'b1};
    motorFreq <= 16'h0456;
    run(MODE_Q_BOTH, 1'b0, 1'b1);
    chk("no demag", 32'h1, {31'h0, dem < 4});
    chk("q ok", 32'h1, {31'h0, accelStart});
    chk("q freq", 32'h00000456, {16'h0, startFreq});
    chk("q dir", 32'h1, {31'h0, startDirCcw});
    chk("q no fallback", 32'h0, brk);
    for (int k = 0; k < 3; k++) begin
      run(qm[k], qr[k], qc[k]);
      chk("q fixed dir", {31'h0, qd[k]}, {31'h0, startDirCcw});
    end
    wr(OFS_IRQ_STAT, 32'h00000007);
    ocReq <= 1'b1;
    run(MODE_Q_CW, 1'b0, 1'b0);
    ocReq <= 1'b0;
    chk("abort", 32'h1, {31'h0, resultFail & ~accelStart});
    chk("no brake", 32'h0, brk);
    rc(OFS_IRQ_STAT, 32'h00000004, "abort flag");
    $display("t_quick done");
  endtask : t_quick

  // reset during the demagnetizing wait must drop the search, brake, irq, setpoint and PI outputs and restore the defaults
  task automatic t_rst;
    wr(OFS_MODE, 32'h00000004);
    startCmd <= 1'b1;
    @(posedge ref_clk);
    startCmd <= 1'b0;
    rc(OFS_STATUS, 32'h00000001, "status demag");
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("rst idle", 32'h0, {31'h0, searchActive | dcInjectionBrake | irq});
    chk("rst levels", 32'h0, {16'h0, currentSetpoint | piOut});
    rc(OFS_MODE, 32'h00000000, "mode rst");
    rc(OFS_RATED, 32'h00001000, "rated rst");
    rc(OFS_DEMAG, 32'h00000032, "demag rst");
    $display("t_rst done");
  endtask : t_rst

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  initial begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end

  // whole sequence needs about 15000 cycles
  initial begin
    #(50000 * 8);
    error_cnt++;
    conclude();
  end

  initial begin
    {rstn, regWr, regRd, startCmd, refNegative, motorCcw, ocReq} = '0;
    regAddr = 8'h00;
    regWdata = 32'h00000000;
    motorFreq = 16'h0000;
    error_cnt = 0;
    cmp_count = 0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs();
    t_off();
    t_ref();
    t_pair();
    t_single();
    t_quick();
    t_rst();
    conclude();
  end
endmodule : test_flying_start_search_control
